// file: logic/lpdrt_pkg.sv
// lpdrt_pkg: register map, field layout and reset values of the low power dac/ref/tia control block
// assumes one 100 mhz clock and a plain register port with 32-bit data
package lpdrt_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [15:0] ADDR_REFERENCE_POWER_CONTROL = 16'h2050;
  localparam logic [15:0] ADDR_BIAS_DAC_OUTPUT_CODES = 16'h2120;
  localparam logic [15:0] ADDR_COMMON_MODE_SWITCH_SELECT = 16'h235c;
  localparam logic [15:0] ADDR_DAC_CONTROL_REGISTER = 16'h2400;
  localparam logic [15:0] ADDR_TIA_SWITCH_REGISTER = 16'h2404;
  localparam logic [15:0] ADDR_TIA_CONTROL_REGISTER = 16'h2408;
  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int FINE_LSB = 0;
  localparam int FINE_W = 12;
  localparam int COARSE_LSB = 12;
  localparam int COARSE_W = 6;
  localparam int CODES_W = 18;
  localparam int BANDGAP_PD_BIT = 0;
  localparam int BUFFER_PD_BIT = 1;
  localparam int REF_W = 2;
  localparam int CM_ENABLE_BIT = 3;
  localparam int CM_RSVD_W = 3;
  localparam int DAC_WRITE_ENABLE_BIT = 0;
  localparam int GAIN_LSB = 5;
  localparam int GAIN_W = 5;
  localparam int DIODE_SW_BIT = 0;
  localparam int EXT_RES_SW_BIT = 9;
  localparam int FEEDBACK_SW_BIT = 10;
  localparam int TIA_SW_W = 16;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : lpdrt_pkg

// file: logic/lpdrt_if.sv
// lpdrt_if: register write strobes and data carried from the decoder to the register bank
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface lpdrt_if;
  logic wr_ref;
  logic wr_codes;
  logic wr_cm;
  logic wr_dacctl;
  logic wr_tiasw;
  logic wr_tiactl;
  logic [31:0] wdata;
  modport dec (output wr_ref, output wr_codes, output wr_cm, output wr_dacctl, output wr_tiasw,
    output wr_tiactl, output wdata);
  modport bank (input wr_ref, input wr_codes, input wr_cm, input wr_dacctl, input wr_tiasw,
    input wr_tiactl, input wdata);
endinterface : lpdrt_if

// file: logic/lpdrt_decode.sv
// lpdrt_decode: turns the address and write strobe into one write strobe per register
// assumes addresses and strobes synchronous to clk_sys
`timescale 1ns/1ps
module lpdrt_decode (
  input wire logic [15:0] addr,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  lpdrt_if.dec wr
);
  assign wr.wr_ref = wr_en && (addr == lpdrt_pkg::ADDR_REFERENCE_POWER_CONTROL);
  assign wr.wr_codes = wr_en && (addr == lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES);
  assign wr.wr_cm = wr_en && (addr == lpdrt_pkg::ADDR_COMMON_MODE_SWITCH_SELECT);
  assign wr.wr_dacctl = wr_en && (addr == lpdrt_pkg::ADDR_DAC_CONTROL_REGISTER);
  assign wr.wr_tiasw = wr_en && (addr == lpdrt_pkg::ADDR_TIA_SWITCH_REGISTER);
  assign wr.wr_tiactl = wr_en && (addr == lpdrt_pkg::ADDR_TIA_CONTROL_REGISTER);
  assign wr.wdata = wr_data;
endmodule : lpdrt_decode

// file: logic/lpdrt_top.sv
// lpdrt_top: register bank driving the low power bias dac codes, reference power-downs,
// common-mode switches and tia switch controls
// assumes a plain register port on clk_sys; analog parts sit outside and follow the outputs
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module lpdrt_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic [11:0] fine_dac_code,
  output logic [5:0] coarse_dac_code,
  output logic ref_buffer_power_down,
  output logic bandgap_power_down,
  output logic common_mode_switch_enable,
  output logic [4:0] tia_gain_resistor_select,
  output logic force_sense_switch_close,
  output logic protection_diode_switch,
  output logic external_gain_resistor_switch,
  output logic buffer_feedback_switch,
  output logic [15:0] tia_switch_state
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  lpdrt_if wr ();
  logic [lpdrt_pkg::CODES_W-1:0] codes;
  logic [lpdrt_pkg::REF_W-1:0] refctl;
  logic cm_en;
  logic [lpdrt_pkg::CM_RSVD_W-1:0] cm_rsvd;
  logic dac_we;
  logic [lpdrt_pkg::GAIN_W-1:0] gain;
  logic [lpdrt_pkg::TIA_SW_W-1:0] tiasw;
  logic force_sense;
  logic [lpdrt_pkg::CODES_W-1:0] next_codes;
  logic [lpdrt_pkg::REF_W-1:0] next_refctl;
  logic next_cm_en;
  logic [lpdrt_pkg::CM_RSVD_W-1:0] next_cm_rsvd;
  logic next_dac_we;
  logic [lpdrt_pkg::GAIN_W-1:0] next_gain;
  logic [lpdrt_pkg::TIA_SW_W-1:0] next_tiasw;
  logic next_force_sense;
  logic [31:0] next_rd_data;

  lpdrt_decode u_decode (
    .addr(addr),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .wr(wr)
  );

  // ------------------------------------------------------------
  // register next values
  // ------------------------------------------------------------
  always_comb begin
    next_codes = codes;
    next_refctl = refctl;
    next_cm_en = cm_en;
    next_cm_rsvd = cm_rsvd;
    next_dac_we = dac_we;
    next_gain = gain;
    next_tiasw = tiasw;
    if (wr.wr_dacctl) begin
      next_dac_we = wr.wdata[lpdrt_pkg::DAC_WRITE_ENABLE_BIT];
    end
    if (!dac_we) begin
      next_codes = '0;
    end else if (wr.wr_codes) begin
      next_codes = wr.wdata[lpdrt_pkg::CODES_W-1:0];
    end
    if (wr.wr_ref) begin
      next_refctl = wr.wdata[lpdrt_pkg::REF_W-1:0];
    end
    if (wr.wr_cm) begin
      next_cm_en = wr.wdata[lpdrt_pkg::CM_ENABLE_BIT];
      next_cm_rsvd = wr.wdata[lpdrt_pkg::CM_RSVD_W-1:0];
    end
    if (wr.wr_tiactl) begin
      next_gain = wr.wdata[lpdrt_pkg::GAIN_LSB +: lpdrt_pkg::GAIN_W];
    end
    if (wr.wr_tiasw) begin
      next_tiasw = wr.wdata[lpdrt_pkg::TIA_SW_W-1:0];
    end
    // loaded from the next gain so the force/sense switches move with the field, from a flop
    next_force_sense = (next_gain != '0);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      codes <= '0;
      refctl <= '0;
      cm_en <= 1'b0;
      cm_rsvd <= '0;
      dac_we <= 1'b0;
      gain <= '0;
      tiasw <= '0;
      force_sense <= 1'b0;
    end else begin
      codes <= next_codes;
      refctl <= next_refctl;
      cm_en <= next_cm_en;
      cm_rsvd <= next_cm_rsvd;
      dac_we <= next_dac_we;
      gain <= next_gain;
      tiasw <= next_tiasw;
      force_sense <= next_force_sense;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    next_rd_data = lpdrt_pkg::UNMAPPED_READ;
    if (rd_en) begin
      unique case (addr)
        lpdrt_pkg::ADDR_REFERENCE_POWER_CONTROL: next_rd_data = {30'h0, refctl};
        lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES: next_rd_data = {14'h0, codes};
        lpdrt_pkg::ADDR_COMMON_MODE_SWITCH_SELECT: next_rd_data = {28'h0, cm_en, cm_rsvd};
        lpdrt_pkg::ADDR_DAC_CONTROL_REGISTER: next_rd_data = {31'h0, dac_we};
        lpdrt_pkg::ADDR_TIA_SWITCH_REGISTER: next_rd_data = {16'h0, tiasw};
        lpdrt_pkg::ADDR_TIA_CONTROL_REGISTER: next_rd_data = {22'h0, gain, 5'h0};
        default: next_rd_data = lpdrt_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= lpdrt_pkg::RESET_VALUE;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // ------------------------------------------------------------
  // analog control outputs
  // ------------------------------------------------------------
  assign fine_dac_code = codes[lpdrt_pkg::FINE_LSB +: lpdrt_pkg::FINE_W];
  assign coarse_dac_code = codes[lpdrt_pkg::COARSE_LSB +: lpdrt_pkg::COARSE_W];
  assign ref_buffer_power_down = refctl[lpdrt_pkg::BUFFER_PD_BIT];
  assign bandgap_power_down = refctl[lpdrt_pkg::BANDGAP_PD_BIT];
  assign common_mode_switch_enable = cm_en;
  assign tia_gain_resistor_select = gain;
  assign force_sense_switch_close = force_sense;
  assign protection_diode_switch = tiasw[lpdrt_pkg::DIODE_SW_BIT];
  assign external_gain_resistor_switch = tiasw[lpdrt_pkg::EXT_RES_SW_BIT];
  assign buffer_feedback_switch = tiasw[lpdrt_pkg::FEEDBACK_SW_BIT];
  assign tia_switch_state = tiasw;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // the assertions decode the raw pins themselves (the code covers use wr.wr_codes), so a decoder fault cannot hide behind its own strobes
  function automatic logic bus_hit(input logic strobe, input logic [15:0] a, input logic [15:0] reg_addr);
    return strobe && (a == reg_addr);
  endfunction : bus_hit

  // every offset that the read mux answers with register contents
  function automatic logic is_mapped(input logic [15:0] a);
    return (a == lpdrt_pkg::ADDR_REFERENCE_POWER_CONTROL) || (a == lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES)
      || (a == lpdrt_pkg::ADDR_COMMON_MODE_SWITCH_SELECT) || (a == lpdrt_pkg::ADDR_DAC_CONTROL_REGISTER)
      || (a == lpdrt_pkg::ADDR_TIA_SWITCH_REGISTER) || (a == lpdrt_pkg::ADDR_TIA_CONTROL_REGISTER);
  endfunction : is_mapped

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // dac code checks
  // ------------------------------------------------------------
  codes_locked_a: assert property (!dac_we |=> codes == '0)
    else $error("dac codes nonzero while writes disabled");
  codes_write_a: assert property (dac_we && bus_hit(wr_en, addr, lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES)
    |=> fine_dac_code == $past(wr_data[11:0]))
    else $error("fine dac code write not taken");
  coarse_field_a: assert property (dac_we && bus_hit(wr_en, addr, lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES)
    |=> coarse_dac_code == $past(wr_data[17:12]))
    else $error("coarse dac code not taken from bits 17:12");
  codes_hold_a: assert property (dac_we && !bus_hit(wr_en, addr, lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES)
    |=> $stable({coarse_dac_code, fine_dac_code}))
    else $error("dac codes moved without a code write");
  codes_ignore_a: assert property (!dac_we && bus_hit(wr_en, addr, lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES)
    |=> {coarse_dac_code, fine_dac_code} == 18'h0)
    else $error("dac code write taken while writes disabled");
  dac_enable_a: assert property (bus_hit(wr_en, addr, lpdrt_pkg::ADDR_DAC_CONTROL_REGISTER)
    |=> dac_we == $past(wr_data[0]))
    else $error("dac write enable not following bit 0");
  enable_hold_a: assert property (!bus_hit(wr_en, addr, lpdrt_pkg::ADDR_DAC_CONTROL_REGISTER)
    |=> $stable(dac_we))
    else $error("dac write enable moved without a write");

  // ------------------------------------------------------------
  // reference and common-mode checks
  // ------------------------------------------------------------
  buffer_pd_a: assert property (bus_hit(wr_en, addr, lpdrt_pkg::ADDR_REFERENCE_POWER_CONTROL)
    |=> ref_buffer_power_down == $past(wr_data[1]))
    else $error("buffer power-down not following bit 1");
  bandgap_pd_a: assert property (bus_hit(wr_en, addr, lpdrt_pkg::ADDR_REFERENCE_POWER_CONTROL)
    |=> bandgap_power_down == $past(wr_data[0]))
    else $error("band gap power-down not following bit 0");
  ref_hold_a: assert property (!bus_hit(wr_en, addr, lpdrt_pkg::ADDR_REFERENCE_POWER_CONTROL)
    |=> $stable({ref_buffer_power_down, bandgap_power_down}))
    else $error("reference power-downs moved without a write");
  cm_switch_a: assert property (bus_hit(wr_en, addr, lpdrt_pkg::ADDR_COMMON_MODE_SWITCH_SELECT)
    |=> common_mode_switch_enable == $past(wr_data[3]))
    else $error("common-mode switch not following bit 3");
  cm_hold_a: assert property (!bus_hit(wr_en, addr, lpdrt_pkg::ADDR_COMMON_MODE_SWITCH_SELECT)
    |=> $stable(common_mode_switch_enable))
    else $error("common-mode switch moved without a write");
  cm_spare_a: assert property (bus_hit(wr_en, addr, lpdrt_pkg::ADDR_COMMON_MODE_SWITCH_SELECT)
    |=> cm_rsvd == $past(wr_data[2:0]))
    else $error("common-mode low bits not stored");

  // ------------------------------------------------------------
  // tia switch checks
  // ------------------------------------------------------------
  force_sense_a: assert property (bus_hit(wr_en, addr, lpdrt_pkg::ADDR_TIA_CONTROL_REGISTER)
    |=> force_sense_switch_close == ($past(wr_data[9:5]) != 5'h0))
    else $error("force/sense switch wrong for gain select");
  force_track_a: assert property (force_sense_switch_close == (tia_gain_resistor_select != 5'h0))
    else $error("force/sense switch out of step with gain select");
  gain_write_a: assert property (bus_hit(wr_en, addr, lpdrt_pkg::ADDR_TIA_CONTROL_REGISTER)
    |=> tia_gain_resistor_select == $past(wr_data[9:5]))
    else $error("gain select not taken from bits 9:5");
  gain_hold_a: assert property (!bus_hit(wr_en, addr, lpdrt_pkg::ADDR_TIA_CONTROL_REGISTER)
    |=> $stable({tia_gain_resistor_select, force_sense_switch_close}))
    else $error("gain select moved without a write");
  diode_switch_a: assert property (bus_hit(wr_en, addr, lpdrt_pkg::ADDR_TIA_SWITCH_REGISTER)
    |=> protection_diode_switch == $past(wr_data[0]))
    else $error("protection diode switch not following bit 0");
  ext_switch_a: assert property (bus_hit(wr_en, addr, lpdrt_pkg::ADDR_TIA_SWITCH_REGISTER)
    |=> external_gain_resistor_switch == $past(wr_data[9]))
    else $error("external resistor switch not following bit 9");
  feedback_sw_a: assert property (bus_hit(wr_en, addr, lpdrt_pkg::ADDR_TIA_SWITCH_REGISTER)
    |=> buffer_feedback_switch == $past(wr_data[10]))
    else $error("buffer feedback switch not following bit 10");
  tiasw_word_a: assert property (bus_hit(wr_en, addr, lpdrt_pkg::ADDR_TIA_SWITCH_REGISTER)
    |=> tia_switch_state == $past(wr_data[15:0]))
    else $error("tia switch word not stored");
  tiasw_hold_a: assert property (!bus_hit(wr_en, addr, lpdrt_pkg::ADDR_TIA_SWITCH_REGISTER)
    |=> $stable(tia_switch_state))
    else $error("tia switches moved without a write");

  // ------------------------------------------------------------
  // read path checks
  // ------------------------------------------------------------
  ref_reserved_a: assert property (bus_hit(rd_en, addr, lpdrt_pkg::ADDR_REFERENCE_POWER_CONTROL)
    |=> rd_data == {30'h0, $past(ref_buffer_power_down), $past(bandgap_power_down)})
    else $error("reserved bits read nonzero");
  codes_read_a: assert property (bus_hit(rd_en, addr, lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES)
    |=> rd_data == {14'h0, $past(coarse_dac_code), $past(fine_dac_code)})
    else $error("dac code read wrong");
  cm_read_a: assert property (bus_hit(rd_en, addr, lpdrt_pkg::ADDR_COMMON_MODE_SWITCH_SELECT)
    |=> rd_data[31:4] == 28'h0 && rd_data[3] == $past(common_mode_switch_enable))
    else $error("common-mode register read wrong");
  tiasw_read_a: assert property (bus_hit(rd_en, addr, lpdrt_pkg::ADDR_TIA_SWITCH_REGISTER)
    |=> rd_data == {16'h0, $past(tia_switch_state)})
    else $error("tia switch register read wrong");
  tiactl_read_a: assert property (bus_hit(rd_en, addr, lpdrt_pkg::ADDR_TIA_CONTROL_REGISTER)
    |=> rd_data == {22'h0, $past(tia_gain_resistor_select), 5'h0})
    else $error("tia control register read wrong");
  dacctl_read_a: assert property (bus_hit(rd_en, addr, lpdrt_pkg::ADDR_DAC_CONTROL_REGISTER)
    |=> rd_data == {31'h0, $past(dac_we)})
    else $error("dac control register read wrong");
  unmapped_read_a: assert property (rd_en && !is_mapped(addr)
    |=> rd_data == 32'h0)
    else $error("unmapped read returned nonzero");
  // read data stand for one cycle only, so an idle bus must show zero
  rd_idle_a: assert property (!rd_en |=> rd_data == 32'h0)
    else $error("read data nonzero without a read");

  // ------------------------------------------------------------
  // covers
  // ------------------------------------------------------------
  ext_res_c: cover property (bus_hit(wr_en, addr, lpdrt_pkg::ADDR_TIA_CONTROL_REGISTER) && wr_data[9:5] == 5'h0
    ##1 external_gain_resistor_switch);
  code_update_c: cover property (dac_we && wr.wr_codes ##1 codes != '0);
  dac_lock_c: cover property (!dac_we && wr.wr_codes);
  ref_down_c: cover property (ref_buffer_power_down && bandgap_power_down);
  buffer_mode_c: cover property (buffer_feedback_switch && force_sense_switch_close);
endmodule : lpdrt_top

// file: verif/tb_top.sv
// tb_top: self-checking bench for the low power dac/ref/tia register bank
// assumes lpdrt_pkg and the design files are compiled first; assertions live in the design
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  logic clk_sys;
  logic rst_n;
  logic [15:0] addr;
  logic [31:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_data;
  logic [11:0] fine_dac_code;
  logic [5:0] coarse_dac_code;
  logic ref_buffer_power_down;
  logic bandgap_power_down;
  logic common_mode_switch_enable;
  logic [4:0] tia_gain_resistor_select;
  logic force_sense_switch_close;
  logic protection_diode_switch;
  logic external_gain_resistor_switch;
  logic buffer_feedback_switch;
  logic [15:0] tia_switch_state;
  int fail_count = 0;
  int n_compared = 0;
  logic [15:0] row_addr [10];
  logic [31:0] row_data [10];
  logic [31:0] row_exp [10];
  lpdrt_top lpdrt_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .fine_dac_code(fine_dac_code), .coarse_dac_code(coarse_dac_code),
    .ref_buffer_power_down(ref_buffer_power_down), .bandgap_power_down(bandgap_power_down),
    .common_mode_switch_enable(common_mode_switch_enable), .tia_gain_resistor_select(tia_gain_resistor_select),
    .force_sense_switch_close(force_sense_switch_close), .protection_diode_switch(protection_diode_switch),
    .external_gain_resistor_switch(external_gain_resistor_switch),
    .buffer_feedback_switch(buffer_feedback_switch), .tia_switch_state(tia_switch_state));
  // ------------------------------------------------------------
  // clock, bus tasks, closing
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    #1;
  endtask : reg_write
  task automatic reg_check(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    `CHK(rd_data, exp)
  endtask : reg_check
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    complete_run();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    addr = 16'h0000;
    wr_data = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    // write then read back: address, data, expected read value
    row_addr = '{lpdrt_pkg::ADDR_REFERENCE_POWER_CONTROL, lpdrt_pkg::ADDR_REFERENCE_POWER_CONTROL,
      lpdrt_pkg::ADDR_COMMON_MODE_SWITCH_SELECT, lpdrt_pkg::ADDR_COMMON_MODE_SWITCH_SELECT,
      lpdrt_pkg::ADDR_DAC_CONTROL_REGISTER, lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES,
      lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES, lpdrt_pkg::ADDR_TIA_SWITCH_REGISTER,
      lpdrt_pkg::ADDR_TIA_CONTROL_REGISTER, 16'h2100};
    row_data = '{32'h0000_0002, 32'hffff_ffff, 32'hffff_fff7, 32'h0000_0008, 32'h0000_0001, 32'hfff0_0fff,
      32'h0003_f123, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
    row_exp = '{32'h0000_0002, 32'h0000_0003, 32'h0000_0007, 32'h0000_0008, 32'h0000_0001, 32'h0000_0fff,
      32'h0003_f123, 32'h0000_ffff, 32'h0000_03e0, 32'h0000_0000};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    `CHK({fine_dac_code, coarse_dac_code, ref_buffer_power_down, bandgap_power_down}, 20'h00000)
    reg_check(lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES, lpdrt_pkg::RESET_VALUE);
    reg_check(lpdrt_pkg::ADDR_COMMON_MODE_SWITCH_SELECT, lpdrt_pkg::RESET_VALUE);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      reg_write(row_addr[i], row_data[i]);
      reg_check(row_addr[i], row_exp[i]);
    end
    $display("test table done");
    reg_write(lpdrt_pkg::ADDR_REFERENCE_POWER_CONTROL, 32'h0000_0002);
    `CHK({ref_buffer_power_down, bandgap_power_down}, 2'b10)
    reg_write(lpdrt_pkg::ADDR_REFERENCE_POWER_CONTROL, 32'h0000_0001);
    `CHK({ref_buffer_power_down, bandgap_power_down}, 2'b01)
    `CHK({coarse_dac_code, fine_dac_code}, 18'h3f123)
    `CHK(common_mode_switch_enable, 1'b1)
    reg_write(lpdrt_pkg::ADDR_COMMON_MODE_SWITCH_SELECT, 32'h0000_0000);
    `CHK(common_mode_switch_enable, 1'b0)
    `CHK({tia_gain_resistor_select, force_sense_switch_close}, 6'h3f)
    reg_write(lpdrt_pkg::ADDR_TIA_CONTROL_REGISTER, 32'h0000_0020);
    `CHK({tia_gain_resistor_select, force_sense_switch_close}, 6'h03)
    reg_write(lpdrt_pkg::ADDR_TIA_CONTROL_REGISTER, 32'hffff_fc1f);
    `CHK({tia_gain_resistor_select, force_sense_switch_close}, 6'h00)
    $display("test gain done");
    reg_write(lpdrt_pkg::ADDR_TIA_SWITCH_REGISTER, 32'h0000_0201);
    `CHK({protection_diode_switch, external_gain_resistor_switch, buffer_feedback_switch}, 3'b110)
    `CHK(tia_switch_state, 16'h0201)
    reg_write(lpdrt_pkg::ADDR_TIA_SWITCH_REGISTER, 32'h0000_0400);
    `CHK({protection_diode_switch, external_gain_resistor_switch, buffer_feedback_switch}, 3'b001)
    $display("test switches done");
    reg_write(lpdrt_pkg::ADDR_DAC_CONTROL_REGISTER, 32'h0000_0000);
    #10;
    `CHK({coarse_dac_code, fine_dac_code}, 18'h00000)
    reg_write(lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES, 32'h0002_0456);
    reg_check(lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES, 32'h0000_0000);
    // enable then code write on the very next cycle
    @(posedge clk_sys);
    addr <= lpdrt_pkg::ADDR_DAC_CONTROL_REGISTER;
    wr_data <= 32'h0000_0001;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    addr <= lpdrt_pkg::ADDR_BIAS_DAC_OUTPUT_CODES;
    wr_data <= 32'h0001_0abc;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    #1;
    `CHK({coarse_dac_code, fine_dac_code}, 18'h10abc)
    $display("test write enable done");
    @(posedge clk_sys);
    rst_n <= 1'b0;
    #1;
    `CHK({fine_dac_code, tia_switch_state, common_mode_switch_enable, bandgap_power_down}, 30'h0)
    @(posedge clk_sys);
    rst_n <= 1'b1;
    reg_check(lpdrt_pkg::ADDR_TIA_CONTROL_REGISTER, lpdrt_pkg::RESET_VALUE);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule : tb_top
